// ---- src/fpe_pkg.sv ----
// flow pulse emitter: shared constants and the emitter state encoding.
// assumes a single 125 MHz clock; every time below is in its own unit.
package fpe_pkg;

   // clock rate and derived millisecond divider
   localparam int CLOCK_HZ      = 125_000_000;
   localparam int MS_PER_S      = 1000;
   localparam int MS_CYCLES_DEF = CLOCK_HZ / MS_PER_S;

   // schedule, in milliseconds
   localparam int PERIOD_MS      = 1000;
   localparam int TEST_MEAS_MS   = 125;
   localparam int PULSE_HIGH_MS  = 3;
   localparam int PULSE_LOW_MS   = 2;
   localparam int BURST_PAUSE_MS = 30;

   // start-up settling time, in seconds
   localparam int SETTLE_S = 16;

   // calculator line: low times in milliseconds
   localparam int TEST_ENTRY_MS = 200;
   localparam int CMD_MIN_MS    = 5;
   localparam int LOW_SAT_MS    = 255;

   // pulse arithmetic: flow in ml/s times meter factor x10 gives units
   localparam int MAX_PULSES    = 125;
   localparam int BURST_LEN     = 16;
   localparam int PULSE_UNITS   = 10000;
   localparam int SAT_UNITS     = MAX_PULSES * PULSE_UNITS;
   localparam int HIST_DEPTH    = 8;
   localparam int HIST_SHIFT    = 3;

   // defaults of the top-level parameters
   localparam int FACTOR_X10_DEF = 1000;
   localparam int CUTOFF_ML_DEF  = 1;

   typedef enum logic [1:0] {
      FPE_IDLE,
      FPE_HIGH,
      FPE_LOW,
      FPE_PAUSE
   } fpe_emit_t;

endpackage

// ---- src/fpe_flow_pulse_emitter.sv ----
// flow pulse emitter: averages flow samples, emits flow-proportional
// pulse bursts once a second, and obeys test mode and start/stop on the
// calculator line. flow_ml comes from logic on the same clock; line_in is
// an outside pin and is synchronised first.
`timescale 1ns/1ns
`default_nettype none

module fpe_flow_pulse_emitter #(
   parameter int MS_CYCLES  = fpe_pkg::MS_CYCLES_DEF,
   parameter int FACTOR_X10 = fpe_pkg::FACTOR_X10_DEF,
   parameter int CUTOFF_ML  = fpe_pkg::CUTOFF_ML_DEF
) (
   // clock and reset
   input  wire logic               clock,
   input  wire logic               sys_rst,
   // flow measurement, ml per second, signed
   input  wire logic signed [15:0] flow_ml,
   // calculator signal line
   input  wire logic               line_in,
   // pulse output and status
   output logic                    pulse_out,
   output logic                    test_mode,
   output logic                    acc_run,
   output logic                    settled,
   output logic [23:0]             acc_pulses
);

   typedef struct packed {
      logic [16:0]            ms_div;
      logic [9:0]             ms_in_sec;
      logic [6:0]             ms_in_meas;
      logic [7:0][15:0]       hist;
      logic [31:0]            acc;
      logic [6:0]             pend;
      logic [4:0]             ph;
      logic [4:0]             burst;
      fpe_pkg::fpe_emit_t     emit;
      logic                   pulse;
      logic                   line_s1;
      logic                   line_s2;
      logic [7:0]             low_ms;
      logic                   test_mode;
      logic                   run;
      logic                   first_done;
      logic [4:0]             up_sec;
      logic                   settled;
      logic [23:0]            total;
   } fpe_state_t;

   localparam logic [16:0] MS_LAST   = 17'(MS_CYCLES - 1);
   localparam logic [9:0]  SEC_LAST  = 10'(fpe_pkg::PERIOD_MS - 1);
   localparam logic [6:0]  MEAS_LAST = 7'(fpe_pkg::TEST_MEAS_MS - 1);
   localparam logic [4:0]  HIGH_LAST = 5'(fpe_pkg::PULSE_HIGH_MS - 1);
   localparam logic [4:0]  LOW_LAST  = 5'(fpe_pkg::PULSE_LOW_MS - 1);
   localparam logic [4:0]  PAUSE_LAST = 5'(fpe_pkg::BURST_PAUSE_MS - 1);
   localparam logic [4:0]  BURST_N   = 5'(fpe_pkg::BURST_LEN);
   localparam logic [4:0]  SETTLE_N  = 5'(fpe_pkg::SETTLE_S);
   localparam logic [7:0]  LOW_SAT   = 8'(fpe_pkg::LOW_SAT_MS);
   localparam logic [7:0]  ENTRY_N   = 8'(fpe_pkg::TEST_ENTRY_MS);
   localparam logic [7:0]  CMD_N     = 8'(fpe_pkg::CMD_MIN_MS);
   localparam logic signed [18:0] CUTOFF = 19'(CUTOFF_ML);
   localparam logic [15:0] FACTOR    = 16'(FACTOR_X10);
   localparam logic [32:0] SAT_U     = 33'(fpe_pkg::SAT_UNITS);
   localparam logic [32:0] PULSE_U   = 33'(fpe_pkg::PULSE_UNITS);
   localparam logic [6:0]  MAX_P     = 7'(fpe_pkg::MAX_PULSES);

   fpe_state_t r_reg;
   fpe_state_t r_next;

   logic               ms_tick;
   logic               sec_tick;
   logic               meas_tick;
   logic signed [18:0] hist_sum;
   logic signed [18:0] avg;
   logic [31:0]        inc;
   logic [32:0]        units;
   logic [6:0]         n_pulses;
   logic [32:0]        n_units;

   always_comb begin
      r_next = r_reg;

      // one-millisecond enable from the divider
      ms_tick = (r_reg.ms_div == MS_LAST);
      r_next.ms_div = ms_tick ? '0 : r_reg.ms_div + 17'h1;
      sec_tick = ms_tick && (r_reg.ms_in_sec == SEC_LAST);
      if (ms_tick) begin
         r_next.ms_in_sec  = sec_tick ? '0 : r_reg.ms_in_sec + 10'h1;
         r_next.ms_in_meas = (r_reg.ms_in_meas == MEAS_LAST) ? '0
                           : r_reg.ms_in_meas + 7'h1;
      end
      // test mode samples eight times as often, same arithmetic after
      meas_tick = r_reg.test_mode ? (ms_tick && r_reg.ms_in_meas == MEAS_LAST)
                                  : sec_tick;

      // moving average over the sample history
      hist_sum = '0;
      for (int i = 0; i < fpe_pkg::HIST_DEPTH; i++) begin
         hist_sum = hist_sum + 19'(signed'(r_reg.hist[i]));
      end
      avg = hist_sum >>> fpe_pkg::HIST_SHIFT;
      if (meas_tick) begin
         r_next.hist = {r_reg.hist[6:0], flow_ml};
      end

      // negative and sub-cut-off flow contribute nothing
      inc = (avg >= CUTOFF) ? 32'(avg[15:0]) * 32'(FACTOR) : '0;
      units = 33'(r_reg.acc) + 33'(inc);
      // capping the carry keeps saturation exactly at the maximum rate
      if (units > SAT_U) begin
         units = SAT_U;
      end
      n_pulses = 7'(units / PULSE_U);
      n_units  = 33'(n_pulses) * PULSE_U;

      if (sec_tick) begin
         r_next.acc = 32'(units - n_units);
         r_next.first_done = 1'b1;
         // the very first period has no history yet: it stays silent
         if (r_reg.first_done && (!r_reg.test_mode || r_reg.run)) begin
            r_next.pend = n_pulses;
         end else begin
            r_next.pend = '0;
         end
         if (r_reg.up_sec != SETTLE_N) begin
            r_next.up_sec = r_reg.up_sec + 5'h1;
         end
      end
      r_next.settled = (r_reg.up_sec == SETTLE_N);

      // burst emitter, timed in milliseconds
      unique case (r_reg.emit)
         fpe_pkg::FPE_IDLE: begin
            // wait for a ms tick: first pulse is full width, the second never slips
            if (r_reg.pend != '0 && ms_tick) begin
               r_next.emit  = fpe_pkg::FPE_HIGH;
               r_next.pulse = 1'b1;
               r_next.ph    = '0;
               r_next.burst = '0;
            end
         end
         fpe_pkg::FPE_HIGH: begin
            if (ms_tick) begin
               r_next.ph = r_reg.ph + 5'h1;
               if (r_reg.ph == HIGH_LAST) begin
                  r_next.emit  = fpe_pkg::FPE_LOW;
                  r_next.pulse = 1'b0;
                  r_next.ph    = '0;
                  r_next.pend  = r_reg.pend - 7'h1;
                  r_next.burst = r_reg.burst + 5'h1;
                  if (r_reg.test_mode && r_reg.run) begin
                     r_next.total = r_reg.total + 24'h1;
                  end
               end
            end
         end
         fpe_pkg::FPE_LOW: begin
            if (ms_tick) begin
               r_next.ph = r_reg.ph + 5'h1;
               if (r_reg.ph == LOW_LAST) begin
                  r_next.ph = '0;
                  if (r_reg.pend == '0) begin
                     r_next.emit = fpe_pkg::FPE_IDLE;
                  end else if (r_reg.burst == BURST_N) begin
                     r_next.emit  = fpe_pkg::FPE_PAUSE;
                     r_next.burst = '0;
                  end else begin
                     r_next.emit  = fpe_pkg::FPE_HIGH;
                     r_next.pulse = 1'b1;
                  end
               end
            end
         end
         fpe_pkg::FPE_PAUSE: begin
            if (ms_tick) begin
               r_next.ph = r_reg.ph + 5'h1;
               if (r_reg.ph == PAUSE_LAST) begin
                  r_next.emit  = fpe_pkg::FPE_HIGH;
                  r_next.pulse = 1'b1;
                  r_next.ph    = '0;
               end
            end
         end
      endcase

      // calculator line: idle high, low time selects the command
      r_next.line_s1 = line_in;
      r_next.line_s2 = r_reg.line_s1;
      if (!r_reg.line_s2) begin
         if (ms_tick && r_reg.low_ms != LOW_SAT) begin
            r_next.low_ms = r_reg.low_ms + 8'h1;
         end
      end else begin
         r_next.low_ms = '0;
         if (r_reg.low_ms >= ENTRY_N) begin
            r_next.test_mode = !r_reg.test_mode;
            r_next.run       = 1'b0;
         end else if (r_reg.low_ms >= CMD_N && r_reg.test_mode) begin
            r_next.run = !r_reg.run;
            if (!r_reg.run) begin
               r_next.total = '0;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         r_reg         <= '0;
         r_reg.emit    <= fpe_pkg::FPE_IDLE;
         r_reg.line_s1 <= 1'b1;
         r_reg.line_s2 <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign pulse_out  = r_reg.pulse;
   assign test_mode  = r_reg.test_mode;
   assign acc_run    = r_reg.run;
   assign settled    = r_reg.settled;
   assign acc_pulses = r_reg.total;

   // checks
   logic [31:0] high_len_reg;
   always_ff @(posedge clock) begin
      if (sys_rst || !r_reg.pulse) begin
         high_len_reg <= '0;
      end else begin
         high_len_reg <= high_len_reg + 32'h1;
      end
   end

   AST_PULSE_WIDTH: assert property (@(posedge clock) disable iff (sys_rst)
      $fell(pulse_out) |-> high_len_reg == 32'(fpe_pkg::PULSE_HIGH_MS * MS_CYCLES))
      else $error("pulse high time wrong");
   AST_IDLE_FIRST: assert property (@(posedge clock) disable iff (sys_rst)
      !r_reg.first_done |-> !pulse_out && r_reg.pend == '0)
      else $error("pulse before first period");
   AST_CLAMP: assert property (@(posedge clock) disable iff (sys_rst)
      sec_tick |=> r_reg.pend <= MAX_P && r_reg.acc < fpe_pkg::PULSE_UNITS)
      else $error("period count not clamped");
   AST_CUTOFF: assert property (@(posedge clock) disable iff (sys_rst)
      (sec_tick && avg < CUTOFF && r_reg.acc == '0) |=> r_reg.pend == '0)
      else $error("pulses below cut-off");
   AST_SAT: assert property (@(posedge clock) disable iff (sys_rst)
      (sec_tick && r_reg.first_done && !r_reg.test_mode && units == SAT_U)
      |=> r_reg.pend == MAX_P)
      else $error("saturation count wrong");
   AST_PAUSE: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(r_reg.emit == fpe_pkg::FPE_PAUSE) |-> !pulse_out && $past(r_reg.burst) == BURST_N)
      else $error("pause without full burst");
   AST_GATE: assert property (@(posedge clock) disable iff (sys_rst)
      (sec_tick && r_reg.test_mode && !r_reg.run) |=> r_reg.pend == '0)
      else $error("pulses while stopped");
   AST_PERIOD: assert property (@(posedge clock) disable iff (sys_rst)
      sec_tick |=> r_reg.ms_in_sec == '0 && r_reg.first_done)
      else $error("period restart wrong");
   AST_SETTLE: assert property (@(posedge clock) disable iff (sys_rst)
      settled |-> r_reg.up_sec == SETTLE_N)
      else $error("settled too early");

endmodule

`default_nettype wire

// ---- bench/fpe_calc_model.sv ----
// calculator model: pulls the signal line low on request, counts pulses.
// assumes the bench asks for one low time at a time, in ms ticks.
`timescale 1ns/1ns
`default_nettype none
module fpe_calc_model #(
   parameter int MSC = 2
) (
   // clock
   input  wire logic        clock,
   // request from bench
   input  wire logic        go,
   input  wire logic [15:0] low_ms,
   output logic             busy,
   // sensor side
   input  wire logic        pulse_out,
   output logic             line_in,
   output logic [23:0]      pulse_cnt
);
   int   left;
   logic pulse_d;
   initial begin
      busy = 1'b0;
      line_in = 1'b1;
      pulse_cnt = 24'h000000;
      pulse_d = 1'b0;
   end
   always @(posedge clock) begin
      pulse_d <= pulse_out;
      if (pulse_out && !pulse_d)
         pulse_cnt <= pulse_cnt + 24'h000001;
      // only the calculator pulls the line; it rests high otherwise
      if (go && !busy) begin
         left <= int'(low_ms) * MSC;
         busy <= 1'b1;
         line_in <= 1'b0;
      end else if (busy && left > 1) begin
         left <= left - 1;
      end else if (busy) begin
         line_in <= 1'b1;
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- bench/fpe_flow_pulse_emitter_tb.sv ----
// flow pulse emitter bench: calculator model on the line, flow from bench.
// assumes a 2-cycle ms tick, so one second lasts 2000 clocks.
`timescale 1ns/1ns
`default_nettype none
module fpe_flow_pulse_emitter_tb;
   localparam int MSC = 2;
   logic               clock, sys_rst, go, pulse_out, test_mode, acc_run;
   logic               settled, busy, line_in;
   logic signed [15:0] flow_ml;
   logic [15:0]        low_ms;
   logic [23:0]        acc_pulses, pulse_cnt, c0;
   logic [7:0]         exp_q[$];
   logic [7:0]         cnt;
   int                 n_mismatch, compares, nperiod, gap, hi, f;
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   fpe_flow_pulse_emitter #(.MS_CYCLES(MSC)) u_dut (.clock(clock), .sys_rst(sys_rst),
      .flow_ml(flow_ml), .line_in(line_in), .pulse_out(pulse_out),
      .test_mode(test_mode), .acc_run(acc_run), .settled(settled), .acc_pulses(acc_pulses));
   fpe_calc_model #(.MSC(MSC)) u_calc (.clock(clock), .go(go), .low_ms(low_ms),
      .busy(busy), .pulse_out(pulse_out), .line_in(line_in), .pulse_cnt(pulse_cnt));
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // a period is over once the output has been quiet for 40 ms
   always @(posedge clock) begin
      if (pulse_out) begin
         if (hi == 0 && cnt != 0 && cnt % 16 == 0)
            check(24'(gap >= 30 * MSC && gap <= 33 * MSC), 24'h000001);
         if (hi == 0)
            cnt = cnt + 8'h01;
         hi = hi + 1;
         gap = 0;
      end else begin
         if (hi != 0)
            check(24'(hi >= 2 * MSC && hi <= 5 * MSC), 24'h000001);
         hi = 0;
         gap = gap + 1;
         if (cnt != 0 && gap == 40 * MSC) begin
            if (exp_q.size() > 0)
               check(24'(cnt), 24'(exp_q.pop_front()));
            cnt = 8'h00;
            nperiod++;
         end
      end
   end
   task automatic line_cmd(input logic [15:0] ms);
      go <= 1'b1;
      low_ms <= ms;
      @(posedge clock);
      go <= 1'b0;
      do @(posedge clock); while (busy);
      repeat (8) @(posedge clock);
   endtask
   task automatic wait_period();
      int n;
      n = nperiod;
      for (int i = 0; i < 3000 && nperiod == n; i++) @(posedge clock);
   endtask
   task automatic secs(input int s);
      repeat (s * 1000 * MSC) @(posedge clock);
   endtask
   initial begin
      void'($urandom(6));
      sys_rst = 1'b1;
      go = 1'b0;
      low_ms = 16'h0000;
      flow_ml = 16'sh0000;
      hi = 0;
      gap = 0;
      cnt = 8'h00;
      nperiod = 0;
      n_mismatch = 0;
      compares = 0;
      repeat (8) @(posedge clock);
      check(24'({pulse_out, test_mode, acc_run, settled}), 24'h000000);
      check(acc_pulses, 24'h000000);
      sys_rst <= 1'b0;
      f = 10 * (10 + $urandom % 90);
      flow_ml <= 16'(f);
      secs(6);
      check(24'(settled), 24'h000000);
      secs(4);
      wait_period();
      exp_q.push_back(8'(f / 10));
      wait_period();
      // 3000 ml/s asks for 300 pulses a second, well over the cap
      flow_ml <= 16'sh0BB8;
      secs(9);
      wait_period();
      exp_q.push_back(8'h7D);
      wait_period();
      check(24'(settled), 24'h000001);
      flow_ml <= -16'sh01F4;
      secs(10);
      c0 = pulse_cnt;
      secs(2);
      check(pulse_cnt, c0);
      f = 10 * (10 + $urandom % 90);
      flow_ml <= 16'(f);
      line_cmd(16'h00C8);
      check(24'({test_mode, acc_run}), 24'h000002);
      secs(2);
      wait_period();
      line_cmd(16'h000A);
      check(24'(acc_run), 24'h000001);
      check(acc_pulses, 24'h000000);
      c0 = pulse_cnt;
      wait_period();
      line_cmd(16'h0003);
      check(24'(acc_run), 24'h000001);
      wait_period();
      wait_period();
      line_cmd(16'h000A);
      check(24'(acc_run), 24'h000000);
      check(acc_pulses, pulse_cnt - c0);
      line_cmd(16'h00C8);
      check(24'({test_mode, acc_run}), 24'h000000);
      summarize();
   end
   initial begin
      repeat (95000) @(posedge clock);
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
